// >>> mcc_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: registers sit at their printed offsets on a plain register port
// Notes: kick figures are in ms, scaled by MCC_SLOW_KHZ; the _TICKS figures are counts of slow oscillator ticks
`ifndef MCC_REGS_SVH
`define MCC_REGS_SVH
`define MCC_ADDR_SYSTEM_CONTROL 16'h0180
`define MCC_ADDR_ANALOG_CONTROL_0 16'h0185
`define MCC_ADDR_ANALOG_CONTROL_2 16'h0187
`define MCC_AC0_RCPD 29
`define MCC_AC0_BIAS 28
`define MCC_AC0_BGAP 27
`define MCC_AC0_LOWPWR 22
`define MCC_AC0_KICKEN 21
`define MCC_AC0_CRYSTAL_POWER_DOWN 20
`define MCC_AC0_HALVE 19
`define MCC_AC0_ADCSEL_LO 16
`define MCC_AC2_BOOST 18
`define MCC_AC2_LOADCAP_LO 16
`define MCC_SC_FAIL 27
`define MCC_SC_MDIV 1
`define MCC_RST_RCPD 1'h1
`define MCC_RST_BIAS 1'h0
`define MCC_RST_BGAP 1'h0
`define MCC_RST_LOWPWR 1'h0
`define MCC_RST_KICKEN 1'h0
`define MCC_RST_CRYSTAL_POWER_DOWN 1'h0
`define MCC_RST_HALVE 1'h1
`define MCC_RST_ADCSEL 2'h0
`define MCC_RST_BOOST 1'h0
`define MCC_RST_LOADCAP 2'h0
`define MCC_RST_MDIV 1'h0
`define MCC_SLOW_KHZ 32
`define MCC_KICK_PERIOD_MS 1000
`define MCC_KICK_WIDTH_MS 1
`define MCC_KICK_WIDTH_TICKS (`MCC_KICK_WIDTH_MS * `MCC_SLOW_KHZ)
`define MCC_DEAD_TICKS 2'h2
`endif

// >>> mcc_pkg.sv
// Purpose: types shared by the clock control block
// Assumes: nothing
// Notes: mode comes from the power manager on the same clock
package mcc_pkg;
  typedef enum logic [1:0] {MCC_METER, MCC_SLEEP, MCC_CURDET} mcc_mode_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mcc_bus_req_t;
  typedef struct packed {
    logic uart_clock;
    logic adc_clock;
    logic meterClk;
  } mcc_clk_out_t;
  typedef struct packed {
    logic [2:0] xtalSync;
    logic [2:0] rcSync;
    logic [2:0] slowSync;
    logic fastRcPd;
    logic biasEn;
    logic bandgapEn;
    logic lowPower;
    logic kickEn;
    logic crystal_power_down;
    logic halveSel;
    logic [1:0] adcSel;
    logic driveBoost;
    logic [1:0] loadCap;
    logic meterDiv;
    logic dead;
    logic [1:0] deadCnt;
    logic onRc;
    logic halvePhase;
    logic [2:0][3:0] divCnt;
    mcc_clk_out_t clkOut;
    logic [15:0] kickCnt;
    logic kick;
    logic failPulse;
    logic fastRcRun;
    logic crystalOn;
    logic lowPowerOut;
    logic clockTrusted;
    logic [31:0] rdata;
  } mcc_state_t;
endpackage : mcc_pkg

// >>> mcc_clock_control.sv
// Purpose: main clock selection, dividers and crystal supervision
// Assumes: oscillator clocks arrive as pins and are sampled at 100 MHz
// Notes: derived clocks are registered toggles, not real clock trees
// Summary of operation
// [R1] - crystal runs after any reset and feeds engine, adc and uart clocks
// [R2] - fast rc oscillator is stopped after any reset
// [R3] - slow rc oscillator always runs; it clocks supervisor, wake-up and filters
// [R4] - two-bit crystal load capacitance select in analog control 2
// [R5] - engine, adc and uart clocks come from main clock via own dividers
// [R6] - crystal power-down bit in analog control 0 stops the crystal
// [R7] - crystal stopping starts fast rc and moves all clocks onto it
// [R8] - in metering mode fast rc stops again once crystal resumes
// [R9] - host enables halving with the fast crystal, disables it otherwise
// [R10] - halving stage is enabled after every reset
// [R11] - adc clock select and metering divider bit adjust clock rates
// [R12] - host sets low-power bit for slow crystal; ignored with fast crystal
// [R13] - host sets drive-boost bit for high-resistance crystals
// [R14] - supervisor gives 1 ms kick each second while crystal is dead
// [R15] - kick disabled by default, enabled by kick enable bit
// [R16] - sleep stops crystal; no automatic restart on wake to current detection
// [R17] - crystal stop raises event and fail flag; flag clears when crystal runs
// [R18] - host enables bandgap and bias before enabling fast rc
// [R19] - fast rc stops in sleep, restarts on wake to current detection
// [R20] - uart timing unreliable on fast rc, so fail flag reads untrusted
// [R21] - clearing rc power-down starts fast rc; sleep sets it, current detection clears
// [R22] - bias and bandgap enables reset off, cleared in sleep, set in current detection
// [R23] - source switch is glitch-free, no short pulse downstream
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "mcc_regs.svh"
module mcc_clock_control
  import mcc_pkg::*;
#(
  parameter logic [15:0] KICK_PERIOD_TICKS = 16'(`MCC_KICK_PERIOD_MS * `MCC_SLOW_KHZ)
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire mcc_bus_req_t busReq,
  output logic [31:0] busRdata,
  input wire mcc_mode_t powerMode,
  input wire logic rawCrystalClock,
  input wire logic fastRcClock,
  input wire logic slowRcClock,
  output mcc_clk_out_t mainClocks,
  output logic crystalRun,
  output logic fastRcRun,
  output logic biasOn,
  output logic bandgapOn,
  output logic crystalKick,
  output logic [1:0] crystalLoadCap,
  output logic crystalDriveBoost,
  output logic crystalLowPower,
  output logic crystalFailEvent,
  output logic uartClockTrusted
);

  mcc_state_t s_r;
  mcc_state_t s_nxt;
  logic xtalRise;
  logic rcRise;
  logic slowTick;
  logic srcTick;
  logic mainTick;
  logic wantRc;
  logic switchWait;
  logic [2:0][1:0] divCode;

  // half period, in main ticks, of a divided clock
  function automatic logic [3:0] halfCount(input logic [1:0] code);
    halfCount = 4'h1 << code;
  endfunction : halfCount

  always_comb
  begin
    s_nxt = s_r;
    // [R3] slow clock is never gated; only sampled
    s_nxt.xtalSync = {s_r.xtalSync[1:0], rawCrystalClock};
    s_nxt.rcSync = {s_r.rcSync[1:0], fastRcClock};
    s_nxt.slowSync = {s_r.slowSync[1:0], slowRcClock};
    xtalRise = s_r.xtalSync[1] & ~s_r.xtalSync[2];
    rcRise = s_r.rcSync[1] & ~s_r.rcSync[2];
    slowTick = s_r.slowSync[1] & ~s_r.slowSync[2];

    // register writes
    if (busReq.wr && busReq.addr == `MCC_ADDR_ANALOG_CONTROL_0)
    begin
      s_nxt.fastRcPd = busReq.wdata[`MCC_AC0_RCPD]; // [R21]
      s_nxt.biasEn = busReq.wdata[`MCC_AC0_BIAS]; // [R22]
      s_nxt.bandgapEn = busReq.wdata[`MCC_AC0_BGAP]; // [R22]
      s_nxt.lowPower = busReq.wdata[`MCC_AC0_LOWPWR];
      s_nxt.kickEn = busReq.wdata[`MCC_AC0_KICKEN]; // [R15]
      s_nxt.crystal_power_down = busReq.wdata[`MCC_AC0_CRYSTAL_POWER_DOWN]; // [R6]
      s_nxt.halveSel = busReq.wdata[`MCC_AC0_HALVE];
      s_nxt.adcSel = busReq.wdata[`MCC_AC0_ADCSEL_LO +: 2]; // [R11]
    end
    if (busReq.wr && busReq.addr == `MCC_ADDR_ANALOG_CONTROL_2)
    begin
      s_nxt.driveBoost = busReq.wdata[`MCC_AC2_BOOST];
      s_nxt.loadCap = busReq.wdata[`MCC_AC2_LOADCAP_LO +: 2]; // [R4]
    end
    if (busReq.wr && busReq.addr == `MCC_ADDR_SYSTEM_CONTROL)
    begin
      s_nxt.meterDiv = busReq.wdata[`MCC_SC_MDIV]; // [R11]
    end

    // mode forcing wins over a write in the same cycle
    if (powerMode == MCC_SLEEP)
    begin
      s_nxt.crystal_power_down = 1'h1; // [R16] stays off until software clears it
      s_nxt.fastRcPd = 1'h1; // [R19] [R21]
      s_nxt.biasEn = 1'h0; // [R22]
      s_nxt.bandgapEn = 1'h0; // [R22]
    end
    else if (powerMode == MCC_CURDET)
    begin
      s_nxt.fastRcPd = 1'h0; // [R19] [R21]
      s_nxt.biasEn = 1'h1; // [R22]
      s_nxt.bandgapEn = 1'h1; // [R22]
    end

    // crystal activity watch on slow ticks
    if (xtalRise)
    begin
      s_nxt.deadCnt = 2'h0;
      s_nxt.dead = 1'h0; // [R17] flag clears when crystal runs
    end
    else if (slowTick)
    begin
      if (s_r.deadCnt == `MCC_DEAD_TICKS)
        s_nxt.dead = 1'h1; // [R17]
      else
        s_nxt.deadCnt = s_r.deadCnt + 2'h1;
    end
    s_nxt.failPulse = s_nxt.dead & ~s_r.dead; // [R17]

    // kick: count slow ticks while dead and enabled
    if (s_r.dead && s_r.kickEn)
    begin
      if (slowTick)
        s_nxt.kickCnt = (s_r.kickCnt == KICK_PERIOD_TICKS - 16'h0001) ? 16'h0000 : s_r.kickCnt + 16'h0001;
    end
    else
      s_nxt.kickCnt = 16'h0000;
    s_nxt.kick = s_r.dead && s_r.kickEn && (s_r.kickCnt < 16'(`MCC_KICK_WIDTH_TICKS)); // [R14] [R15]

    // outside sleep, fast rc runs when enabled by software or when the crystal is dead
    // rc keeps running until the clocks have moved back off it
    s_nxt.fastRcRun = (powerMode != MCC_SLEEP) && (~s_nxt.fastRcPd || s_r.dead || s_r.onRc); // [R2] [R7] [R8] [R19]

    // source selection and halving
    wantRc = s_r.dead && (powerMode != MCC_SLEEP); // [R7] [R8]
    srcTick = s_r.onRc ? rcRise : xtalRise; // [R1] [R7]
    mainTick = srcTick && (s_r.onRc || !s_r.halveSel || s_r.halvePhase);
    divCode[0] = {1'h0, s_r.meterDiv}; // [R11]
    divCode[1] = s_r.adcSel; // [R11]
    divCode[2] = 2'h0;
    // switch only with all outputs low, or once the old source is long dead,
    // so no shortened high phase can escape
    switchWait = wantRc != s_r.onRc;
    if (switchWait && (s_r.clkOut == '0 || s_r.dead))
    begin
      s_nxt.onRc = wantRc; // [R23]
      s_nxt.divCnt = '0; // [R23]
      s_nxt.halvePhase = 1'h0;
    end
    else
    begin
      if (srcTick && !s_r.onRc && s_r.halveSel)
        s_nxt.halvePhase = ~s_r.halvePhase;
      for (int i = 0; i < 3; i++)
      begin
        if (mainTick)
        begin
          if (s_r.divCnt[i] == halfCount(divCode[i]) - 4'h1)
          begin
            s_nxt.divCnt[i] = 4'h0;
            // while a switch waits, a low clock stays low so all three meet at zero
            if (!switchWait || s_r.clkOut[i])
              s_nxt.clkOut[i] = ~s_r.clkOut[i]; // [R5] [R23]
          end
          else
            s_nxt.divCnt[i] = s_r.divCnt[i] + 4'h1;
        end
      end
    end

    // registered copies so every output leaves a flip-flop
    s_nxt.crystalOn = ~s_nxt.crystal_power_down; // [R1] [R6]
    s_nxt.lowPowerOut = s_nxt.lowPower & ~s_nxt.halveSel; // [R12]
    s_nxt.clockTrusted = ~s_nxt.onRc; // [R20]

    // read data stand one cycle only
    s_nxt.rdata = 32'h0000_0000;
    if (busReq.rd)
    begin
      unique case (busReq.addr)
        `MCC_ADDR_ANALOG_CONTROL_0:
        begin
          s_nxt.rdata[`MCC_AC0_RCPD] = s_r.fastRcPd;
          s_nxt.rdata[`MCC_AC0_BIAS] = s_r.biasEn;
          s_nxt.rdata[`MCC_AC0_BGAP] = s_r.bandgapEn;
          s_nxt.rdata[`MCC_AC0_LOWPWR] = s_r.lowPower;
          s_nxt.rdata[`MCC_AC0_KICKEN] = s_r.kickEn;
          s_nxt.rdata[`MCC_AC0_CRYSTAL_POWER_DOWN] = s_r.crystal_power_down;
          s_nxt.rdata[`MCC_AC0_HALVE] = s_r.halveSel;
          s_nxt.rdata[`MCC_AC0_ADCSEL_LO +: 2] = s_r.adcSel;
        end
        `MCC_ADDR_ANALOG_CONTROL_2:
        begin
          s_nxt.rdata[`MCC_AC2_BOOST] = s_r.driveBoost;
          s_nxt.rdata[`MCC_AC2_LOADCAP_LO +: 2] = s_r.loadCap;
        end
        `MCC_ADDR_SYSTEM_CONTROL:
        begin
          // value may not survive a uart running on the rc clock
          s_nxt.rdata[`MCC_SC_FAIL] = s_r.dead; // [R17] [R20]
          s_nxt.rdata[`MCC_SC_MDIV] = s_r.meterDiv;
        end
        default:
          s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.fastRcPd <= `MCC_RST_RCPD; // [R2]
      s_r.biasEn <= `MCC_RST_BIAS; // [R22]
      s_r.bandgapEn <= `MCC_RST_BGAP; // [R22]
      s_r.lowPower <= `MCC_RST_LOWPWR;
      s_r.kickEn <= `MCC_RST_KICKEN; // [R15]
      s_r.crystal_power_down <= `MCC_RST_CRYSTAL_POWER_DOWN; // [R1]
      s_r.halveSel <= `MCC_RST_HALVE; // [R10]
      s_r.adcSel <= `MCC_RST_ADCSEL;
      s_r.driveBoost <= `MCC_RST_BOOST;
      s_r.loadCap <= `MCC_RST_LOADCAP;
      s_r.meterDiv <= `MCC_RST_MDIV;
      s_r.crystalOn <= ~`MCC_RST_CRYSTAL_POWER_DOWN; // [R1]
      s_r.clockTrusted <= 1'h1;
    end
    else if (clkEn)
      s_r <= s_nxt;
  end

  assign busRdata = s_r.rdata;
  assign mainClocks = s_r.clkOut;
  assign crystalRun = s_r.crystalOn; // [R1] [R6]
  assign fastRcRun = s_r.fastRcRun;
  assign biasOn = s_r.biasEn;
  assign bandgapOn = s_r.bandgapEn;
  assign crystalKick = s_r.kick;
  assign crystalLoadCap = s_r.loadCap;
  assign crystalDriveBoost = s_r.driveBoost;
  // low-power has no meaning with the halving (fast crystal) fitted
  assign crystalLowPower = s_r.lowPowerOut; // [R12]
  assign crystalFailEvent = s_r.failPulse;
  assign uartClockTrusted = s_r.clockTrusted; // [R20]

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn || !clkEn);

  sequence s_sleepSeen;
    powerMode == MCC_SLEEP;
  endsequence

  property p_sleepForces;
    s_sleepSeen |=> !crystalRun && !fastRcRun && !biasOn && !bandgapOn;
  endproperty
  a_sleepForces: assert property (p_sleepForces) else $error("sleep did not stop clocks"); // [R16] [R19]

  property p_curdetForces;
    powerMode == MCC_CURDET |=> biasOn && bandgapOn && fastRcRun;
  endproperty
  a_curdetForces: assert property (p_curdetForces) else $error("current detection forcing missing"); // [R19] [R22]

  property p_xtalPdStops;
    busReq.wr && busReq.addr == `MCC_ADDR_ANALOG_CONTROL_0 && busReq.wdata[`MCC_AC0_CRYSTAL_POWER_DOWN] |=> !crystalRun;
  endproperty
  a_xtalPdStops: assert property (p_xtalPdStops) else $error("crystal power-down ignored"); // [R6]

  property p_failEvent;
    $rose(s_r.dead) |-> crystalFailEvent ##1 !crystalFailEvent;
  endproperty
  a_failEvent: assert property (p_failEvent) else $error("fail event not a single pulse"); // [R17]

  property p_failRead;
    busReq.rd && busReq.addr == `MCC_ADDR_SYSTEM_CONTROL |=> busRdata[`MCC_SC_FAIL] == $past(s_r.dead);
  endproperty
  a_failRead: assert property (p_failRead) else $error("fail flag read wrong"); // [R17]

  property p_kickNeedsEnable;
    crystalKick |-> $past(s_r.kickEn) && $past(s_r.dead);
  endproperty
  a_kickNeedsEnable: assert property (p_kickNeedsEnable) else $error("kick without enable"); // [R14] [R15]

  property p_rcWhenOnRc;
    s_r.onRc && powerMode == MCC_METER |=> fastRcRun;
  endproperty
  a_rcWhenOnRc: assert property (p_rcWhenOnRc) else $error("running on stopped rc"); // [R7]

  property p_resetDefaults;
    resetn && !$past(resetn) |-> s_r.halveSel && !fastRcRun && crystalRun && !biasOn;
  endproperty
  a_resetDefaults: assert property (p_resetDefaults) else $error("bad reset defaults"); // [R2] [R10]

  property p_switchSafe;
    s_r.onRc != $past(s_r.onRc) |-> $past(s_r.clkOut) == '0 || $past(s_r.dead);
  endproperty
  a_switchSafe: assert property (p_switchSafe) else $error("unsafe source switch"); // [R23]

endmodule : mcc_clock_control

// >>> mcc_osc_model.sv
// Purpose: behavioural oscillators at the far side of the clock block
// Assumes: periods are scaled so the 100 MHz sampler resolves every edge
// Notes: stall stops the crystal with its enable still high, as a fault would
`timescale 1ns/1ps
module mcc_osc_model
(
  input wire logic crystalRun,
  input wire logic fastRcRun,
  input wire logic stall,
  output logic rawCrystalClock,
  output logic fastRcClock,
  output logic slowRcClock
);
  initial rawCrystalClock = 1'b0;
  initial fastRcClock = 1'b0;
  initial slowRcClock = 1'b0;
  // a stopped oscillator holds its level, it does not keep toggling
  always #40 rawCrystalClock = (crystalRun && !stall) ? ~rawCrystalClock : rawCrystalClock;
  always #50 fastRcClock = fastRcRun ? ~fastRcClock : fastRcClock;
  // no enable input at all: nothing can stop it
  always #200 slowRcClock = ~slowRcClock;
endmodule : mcc_osc_model

// >>> test_metering_clock_control.sv
// Purpose: self-checking bench for the clock control block
// Assumes: kick period shortened to 64 slow ticks, width stays 32
// Notes: rate checks count derived clock rises over fixed windows
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module test_metering_clock_control;
  import mcc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  mcc_bus_req_t busReq = '0;
  mcc_mode_t powerMode = MCC_METER;
  logic stall = 1'b0;
  logic [31:0] busRdata;
  mcc_clk_out_t mainClocks;
  logic rawCrystalClock, fastRcClock, slowRcClock, crystalRun, fastRcRun, biasOn, bandgapOn;
  logic crystalKick, crystalDriveBoost, crystalLowPower, crystalFailEvent, uartClockTrusted;
  logic [1:0] crystalLoadCap;
  logic [31:0] rd;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int u0, a0, m0, u1, a1, m1, k, w;
  typedef struct {logic [15:0] addr; logic [31:0] wdata; logic doWr; logic [31:0] expRd;} row_t;
  row_t rows [6] = '{
    '{16'h0185, 32'h0000_0000, 1'b0, 32'h2008_0000},
    '{16'h0187, 32'h0000_0000, 1'b0, 32'h0000_0000},
    '{16'h0180, 32'h0000_0000, 1'b0, 32'h0000_0000},
    '{16'h0187, 32'h0007_0000, 1'b1, 32'h0007_0000},
    '{16'h0180, 32'h0000_0002, 1'b1, 32'h0000_0002},
    '{16'h0190, 32'hFFFF_FFFF, 1'b1, 32'h0000_0000}};
  always #5 sys_clk = ~sys_clk;
  mcc_clock_control #(.KICK_PERIOD_TICKS(16'h0040)) i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .clkEn(1'b1), .busReq(busReq), .busRdata(busRdata), .powerMode(powerMode),
    .rawCrystalClock(rawCrystalClock), .fastRcClock(fastRcClock), .slowRcClock(slowRcClock),
    .mainClocks(mainClocks), .crystalRun(crystalRun), .fastRcRun(fastRcRun), .biasOn(biasOn),
    .bandgapOn(bandgapOn), .crystalKick(crystalKick), .crystalLoadCap(crystalLoadCap),
    .crystalDriveBoost(crystalDriveBoost), .crystalLowPower(crystalLowPower),
    .crystalFailEvent(crystalFailEvent), .uartClockTrusted(uartClockTrusted));
  mcc_osc_model i_osc (.crystalRun(crystalRun), .fastRcRun(fastRcRun), .stall(stall),
    .rawCrystalClock(rawCrystalClock), .fastRcClock(fastRcClock), .slowRcClock(slowRcClock));
  task wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // hang guard, well above the few thousand cycles each case needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : wr_reg
  task rd_reg(input logic [15:0] a);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 rd = busRdata;
  endtask : rd_reg
  task measure(output int u, output int a, output int m);
    mcc_clk_out_t prev;
    u = 0;
    a = 0;
    m = 0;
    prev = mainClocks;
    repeat (1600)
    begin
      @(posedge sys_clk);
      u += (mainClocks.uart_clock && !prev.uart_clock);
      a += (mainClocks.adc_clock && !prev.adc_clock);
      m += (mainClocks.meterClk && !prev.meterClk);
      prev = mainClocks;
    end
  endtask : measure
  function automatic logic near(input int x, input int y);
    return (x >= y - 2) && (x <= y + 2);
  endfunction : near
  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    `CHK(crystalRun, 1'b1)
    `CHK(fastRcRun, 1'b0)
    `CHK({biasOn, bandgapOn, crystalKick}, 3'h0)
    foreach (rows[i])
    begin
      if (rows[i].doWr)
      begin
        wr_reg(rows[i].addr, rows[i].wdata);
      end
      rd_reg(rows[i].addr);
      `CHK(rd, rows[i].expRd)
    end
    `CHK({crystalLoadCap, crystalDriveBoost}, 3'h7)
    wr_reg(16'h0185, 32'h2048_0000);
    `CHK(crystalLowPower, 1'b0)
    wr_reg(16'h0185, 32'h2040_0000);
    `CHK(crystalLowPower, 1'b1)
    // rates: halving off and fastest dividers, then halve, adc a quarter and engine half of uart
    wr_reg(16'h0185, 32'h2000_0000);
    wr_reg(16'h0180, 32'h0000_0000);
    measure(u0, a0, m0);
    wr_reg(16'h0185, 32'h200A_0000);
    wr_reg(16'h0180, 32'h0000_0002);
    measure(u1, a1, m1);
    `CHK(near(u0, 100), 1'b1)
    `CHK(near(u0, 2 * u1), 1'b1)
    `CHK(near(a0, u0), 1'b1)
    `CHK(near(4 * a1, u1), 1'b1)
    `CHK(near(2 * m1, u1), 1'b1)
    // crystal power-down hands the clocks to the fast rc oscillator
    wr_reg(16'h0185, 32'h2010_0000);
    `CHK(crystalRun, 1'b0)
    for (k = 0; k < 400 && crystalFailEvent !== 1'b1; k++) @(posedge sys_clk);
    `CHK(crystalFailEvent, 1'b1)
    repeat (4) @(posedge sys_clk);
    `CHK({fastRcRun, uartClockTrusted}, 2'h2)
    rd_reg(16'h0180);
    `CHK(rd[27], 1'b1)
    wr_reg(16'h0185, 32'h2000_0000);
    for (k = 0; k < 200 && fastRcRun !== 1'b0; k++) @(posedge sys_clk);
    `CHK({fastRcRun, crystalRun}, 2'h1)
    rd_reg(16'h0180);
    `CHK(rd[27], 1'b0)
    // a stalled crystal without kick enable gets no kick
    stall <= 1'b1;
    for (k = 0; k < 3000 && crystalKick !== 1'b1; k++) @(posedge sys_clk);
    `CHK(crystalKick, 1'b0)
    wr_reg(16'h0185, 32'h2020_0000);
    for (k = 0; k < 3000 && crystalKick !== 1'b1; k++) @(posedge sys_clk);
    for (w = 0; w < 2000 && crystalKick === 1'b1; w++) @(posedge sys_clk);
    // 32 slow ticks of 40 cycles, a tick of slack for sync delay
    `CHK((w >= 1240) && (w <= 1320), 1'b1)
    for (k = 0; k < 3000 && crystalKick !== 1'b1; k++) @(posedge sys_clk);
    `CHK((k + w >= 2520) && (k + w <= 2600), 1'b1)
    stall <= 1'b0;
    wr_reg(16'h0185, 32'h2000_0000);
    // sleep, then wake into current detection
    powerMode <= MCC_SLEEP;
    repeat (200) @(posedge sys_clk);
    `CHK({crystalRun, fastRcRun, biasOn, bandgapOn}, 4'h0)
    powerMode <= MCC_CURDET;
    repeat (200) @(posedge sys_clk);
    `CHK({crystalRun, fastRcRun, biasOn, bandgapOn}, 4'h7)
    powerMode <= MCC_METER;
    wr_reg(16'h0185, 32'h3800_0000);
    wr_reg(16'h0185, 32'h1800_0000);
    `CHK({crystalRun, biasOn, bandgapOn}, 3'h7)
    rd_reg(16'h0185);
    `CHK(rd, 32'h1800_0000)
    // a second reset in mid-run restores the defaults
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_reg(16'h0185);
    `CHK(rd, 32'h2008_0000)
    wrap_up();
  end
endmodule : test_metering_clock_control
